// ### verif/uesc_sie_model.sv
// serial engine stand-in: issues tokens and completion pulses
`default_nettype none
module uesc_sie_model
  import uesc_pkg::*;
(
  // clock
  input wire logic clk,
  // answer from the block
  input wire uesc_resp_e resp,
  input wire logic resp_valid,
  // requests to the block
  output var uesc_tok_s tok,
  output var uesc_ev_s ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tok = '0;
    ev = '0;
  end
  ////////////////////////////////////////
  // answer stands only in the cycle after the token is taken
  task automatic send(input logic [1:0] ep, input logic i, input logic s,
                      output uesc_resp_e r, output logic v);
    @(posedge clk);
    tok <= '{1'b1, ep, i, s};
    @(posedge clk);
    tok <= '{1'b0, ~ep, ~i, ~s}; // released fields never keep the last value
    @(posedge clk);
    r = resp;
    v = resp_valid;
  endtask : send
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= {6'h00, ~e[1:0]};
  endtask : pulse
endmodule : uesc_sie_model
`default_nettype wire

// ### verif/uesc_top_assertions.sv
// port-level checks of the endpoint control block
`default_nettype none
module uesc_top_assertions
  import uesc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // register port
  input wire logic CTRL_EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // serial engine and cpu
  input wire uesc_tok_s TOKEN,
  input wire uesc_ev_s EVENT,
  input wire uesc_resp_e RESP,
  input wire logic RESP_VALID,
  input wire logic [3:0] DATA_TOGGLE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking
    @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////
  // shadow of the disable bits; old value answers a same-edge token
  logic [2:0] off_r;
  always_ff @(posedge CLOCK or negedge RSTN)
    if (!RSTN)
      off_r <= 3'h0;
    else if (REG_WR && REG_ADDR == 5'h0a)
      off_r <= REG_WDATA[7:5];
  ////////////////////////////////////////
  a_en_locked: assert property (
    !CTRL_EN && REG_RD && REG_ADDR == 5'h06 |=> REG_RDATA == 8'h00)
    else $error("enable register readable while controller off");
  a_busrst_irq: assert property (
    EVENT.bus_reset && !REG_WR |=> !IRQ)
    else $error("interrupt survives bus reset");
  a_setup_nak: assert property (
    EVENT.setup_token ##1 !REG_WR ##1 (TOKEN.valid && TOKEN.status && TOKEN.ep == 2'd0
    && CTRL_EN && !REG_WR) |=> RESP_VALID && RESP == RSP_NAK)
    else $error("status stage not refused after setup");
  a_off_silent: assert property (
    TOKEN.valid && TOKEN.ep != 2'd0 && off_r[TOKEN.ep - 2'd1] |=> !RESP_VALID)
    else $error("disabled endpoint answered");
  a_ep0_always: assert property (
    TOKEN.valid && CTRL_EN && TOKEN.ep == 2'd0 |=> RESP_VALID)
    else $error("endpoint 0 gave no answer");
  a_tgl_clear: assert property (
    REG_WR && REG_ADDR == 5'h0a && REG_WDATA[3] |-> ##2 !DATA_TOGGLE[2])
    else $error("toggle reset did not force data0");
  a_busrst_tgl: assert property (
    EVENT.bus_reset |=> DATA_TOGGLE == 4'h0)
    else $error("toggles survive bus reset");
  a_nak_low_zero: assert property (
    REG_RD && REG_ADDR == 5'h09 |=> REG_RDATA[4:0] == 5'h00)
    else $error("reserved refusal bits not zero");
  a_ctg_low_zero: assert property (
    REG_RD && REG_ADDR == 5'h0a |=> REG_RDATA[1:0] == 2'h0)
    else $error("reserved disable bits not zero");
endmodule : uesc_top_assertions
`default_nettype wire

// ### verif/uesc_top_tb_top.sv
// self-checking bench of the endpoint control block
`default_nettype none
module uesc_top_tb_top
  import uesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn;
  logic ctrl_en;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [2:0] bc_write;
  uesc_tok_s token;
  uesc_ev_s evt;
  uesc_resp_e resp;
  logic resp_valid;
  logic [3:0] data_toggle;
  logic irq;
  int n_mismatch = 0;
  int compares = 0;
  always #20 clock = ~clock;
  uesc_top DUT (
    .CLOCK(clock), .RSTN(rstn), .CTRL_EN(ctrl_en), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .BC_WRITE(bc_write), .TOKEN(token), .EVENT(evt), .RESP(resp),
    .RESP_VALID(resp_valid), .DATA_TOGGLE(data_toggle), .IRQ(irq)
  );
  uesc_sie_model u_sie (
    .clk(clock), .resp(resp), .resp_valid(resp_valid), .tok(token), .ev(evt)
  );
  ////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string nm);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(nm, reg_rdata, exp);
  endtask : rd
  task automatic tk(input logic [1:0] ep, input logic i, input logic s, input logic v,
                    input uesc_resp_e e);
    uesc_resp_e r;
    logic rv;
    u_sie.send(ep, i, s, r, rv);
    chk("resp_valid", {7'h0, rv}, {7'h0, v});
    if (v)
      chk("resp", {5'h0, r}, {5'h0, e});
  endtask : tk
  // completion pulse that raises flag bit b
  function automatic logic [7:0] ev_of(input int b);
    case (b)
      5: return 8'h40;
      4: return 8'h23;
      3: return 8'h22;
      2: return 8'h11;
      1: return 8'h10;
      default: return 8'h20;
    endcase
  endfunction : ev_of
  ////////////////////////////////////////
  initial
  begin
    logic [5:0] m;
    logic [5:0] en;
    void'($urandom(56));
    rstn <= 1'b0;
    ctrl_en <= 1'b1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 5'h00;
    reg_wdata <= 8'h00;
    bc_write <= 3'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(5'h06, 8'h00, "enables");
    rd(5'h07, 8'h19, "flags");
    for (int k = 8; k < 11; k++)
      rd(5'(k), 8'h00, "reset value");
    rd(5'h1f, 8'h00, "unmapped");
    ctrl_en <= 1'b0;
    wr(5'h06, 8'hff);
    rd(5'h06, 8'h00, "locked enables");
    ctrl_en <= 1'b1;
    rd(5'h06, 8'h00, "locked enables");
    repeat (6)
    begin
      en = 6'($urandom);
      m = 6'($urandom);
      wr(5'h06, {2'h3, en});
      wr(5'h07, 8'h00);
      for (int b = 0; b < 6; b++)
        if (m[b])
          u_sie.pulse(ev_of(b));
      rd(5'h07, {2'h0, m}, "flags");
      chk("irq", {7'h0, irq}, {7'h0, |(m & en)});
    end
    wr(5'h07, 8'h00);
    u_sie.pulse(8'h11);
    tk(2'd1, 1'b0, 1'b0, 1'b1, RSP_NAK);
    wr(5'h07, 8'h00);
    tk(2'd1, 1'b0, 1'b0, 1'b1, RSP_ACK);
    wr(5'h09, 8'h00);
    tk(2'd2, 1'b1, 1'b0, 1'b1, RSP_NAK);
    rd(5'h09, 8'h40, "refused seen");
    u_sie.pulse(8'h22);
    @(posedge clock);
    bc_write <= 3'h2;
    @(posedge clock);
    bc_write <= 3'h0;
    rd(5'h07, 8'h00, "free flag");
    tk(2'd2, 1'b1, 1'b0, 1'b1, RSP_DATA);
    u_sie.pulse(8'h80);
    tk(2'd0, 1'b1, 1'b1, 1'b1, RSP_NAK);
    wr(5'h08, 8'h40);
    tk(2'd0, 1'b1, 1'b1, 1'b1, RSP_ACK);
    u_sie.pulse(8'h08);
    tk(2'd0, 1'b1, 1'b1, 1'b1, RSP_NAK);
    wr(5'h08, 8'h60);
    rd(5'h08, 8'h20, "ack after stall");
    tk(2'd0, 1'b1, 1'b1, 1'b1, RSP_STALL);
    wr(5'h08, 8'h1f);
    for (int e = 0; e < 5; e++)
      tk(2'(e < 4 ? 3 - e : 0), 1'(e != 2 && e != 3), 1'b0, 1'b1, RSP_STALL);
    u_sie.pulse(8'h80);
    rd(5'h08, 8'h1c, "halts after setup");
    wr(5'h08, 8'h00);
    wr(5'h0a, 8'he0);
    rd(5'h0a, 8'he0, "disables");
    for (int e = 1; e < 4; e++)
      tk(2'(e), 1'(e != 1), 1'b0, 1'b0, RSP_NONE);
    tk(2'd0, 1'b0, 1'b0, 1'b1, RSP_ACK);
    wr(5'h0a, 8'h08);
    u_sie.pulse(8'h22);
    @(posedge clock);
    chk("ep2 toggle", {7'h0, data_toggle[2]}, 8'h01);
    wr(5'h0a, 8'h08);
    repeat (2) @(posedge clock);
    chk("ep2 toggle", {7'h0, data_toggle[2]}, 8'h00);
    u_sie.pulse(8'h40);
    @(posedge clock);
    chk("ep0 toggle", {7'h0, data_toggle[0]}, 8'h01);
    wr(5'h06, 8'h3f);
    u_sie.pulse(8'h04);
    @(posedge clock);
    chk("toggles", {4'h0, data_toggle}, 8'h00);
    rd(5'h06, 8'h00, "enables");
    // every IN endpoint: refusal flag, free flag cleared by byte count, then data
    for (int j = 0; j < 3; j++)
    begin
      wr(5'h09, 8'h00);
      tk(2'(j == 0 ? 0 : j + 1), 1'b1, 1'b0, 1'b1, RSP_NAK);
      rd(5'h09, 8'h20 << j, "refused seen");
      wr(5'h07, 8'h00);
      u_sie.pulse(ev_of(j == 0 ? 0 : j + 2));
      @(posedge clock);
      bc_write <= 3'(1 << j);
      @(posedge clock);
      bc_write <= 3'h0;
      rd(5'h07, 8'h00, "free flag");
      tk(2'(j == 0 ? 0 : j + 1), 1'b1, 1'b0, 1'b1, RSP_DATA);
    end
    close_out();
  end
  // bench needs under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
endmodule : uesc_top_tb_top
bind uesc_top uesc_top_assertions u_chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .CTRL_EN(CTRL_EN), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TOKEN(TOKEN),
  .EVENT(EVENT), .RESP(RESP), .RESP_VALID(RESP_VALID), .DATA_TOGGLE(DATA_TOGGLE),
  .IRQ(IRQ)
);
`default_nettype wire

// ### verilog/uesc_map.svh
// register offsets, bit positions, reset values of the endpoint control block
`ifndef UESC_MAP_SVH
`define UESC_MAP_SVH

// register offsets on the indirect register port
`define UESC_OFS_IRQ_EN 5'h06
`define UESC_OFS_IRQ_FLAGS 5'h07
`define UESC_OFS_STALL 5'h08
`define UESC_OFS_NAK 5'h09
`define UESC_OFS_DIS_TGL 5'h0a

// interrupt enable and flag bit positions
`define UESC_B_SETUP 5
`define UESC_B_EP3_TX 4
`define UESC_B_EP2_TX 3
`define UESC_B_EP1_RX 2
`define UESC_B_EP0_RX 1
`define UESC_B_EP0_TX 0

// stall register bit positions
`define UESC_B_ACK 6
`define UESC_B_STAT_STALL 5
`define UESC_B_EP3_HALT 4
`define UESC_B_EP2_HALT 3
`define UESC_B_EP1_HALT 2
`define UESC_B_EP0_RX_HALT 1
`define UESC_B_EP0_TX_HALT 0

// refused-seen register bit positions
`define UESC_B_EP3_NAK 7
`define UESC_B_EP2_NAK 6
`define UESC_B_EP0_NAK 5

// disable and toggle-reset bit positions
`define UESC_B_EP3_OFF 7
`define UESC_B_EP2_OFF 6
`define UESC_B_EP1_OFF 5
`define UESC_B_EP3_TGL 4
`define UESC_B_EP2_TGL 3
`define UESC_B_EP1_TGL 2

// reset values
`define UESC_RST_IRQ_EN 6'h00
`define UESC_RST_FLAGS 6'h19
`define UESC_RST_STALL 6'h00

`endif

// ### verilog/uesc_pkg.sv
// types shared by the endpoint control block
`default_nettype none
package uesc_pkg;

  // token from the serial engine, asking how to answer
  typedef struct packed {
    logic valid;
    logic [1:0] ep;
    logic is_in;
    logic status;
  } uesc_tok_s;

  // completion events from the serial engine, one-cycle pulses
  typedef struct packed {
    logic setup_token;
    logic setup_ok;
    logic in_acked;
    logic out_ok;
    logic status_acked;
    logic bus_reset;
    logic [1:0] ep;
  } uesc_ev_s;

  typedef enum logic [2:0] {
    RSP_NONE,
    RSP_ACK,
    RSP_NAK,
    RSP_STALL,
    RSP_DATA
  } uesc_resp_e;

endpackage : uesc_pkg
`default_nettype wire

// ### verilog/uesc_toggle.sv
// data toggle of one endpoint
`default_nettype none
module uesc_toggle
  import uesc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic clear,
  input wire logic force_one,
  input wire logic advance,
  // state
  output logic toggle_r
);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      toggle_r <= 1'b0;
    else if (clear)
      toggle_r <= 1'b0;
    else if (force_one)
      toggle_r <= 1'b1;
    else if (advance)
      toggle_r <= ~toggle_r;
  end

endmodule : uesc_toggle
`default_nettype wire

// ### verilog/uesc_top.sv
// endpoint interrupt, stall, refusal, disable and toggle control
//
// Operation
// - endpoint interrupt-enable register reachable only while controller is enabled
// - bus reset clears all endpoint interrupt-enable bits
// - interrupt raised when any flag and its enable are both set
// - setup-ready flag set after eight clean setup bytes, sticky
// - IN buffer-free flag set after IN data acked by host
// - IN buffer-free flag cleared by software or byte-count write
// - OUT data-ready flag set after OUT packet received and acked
// - clearing OUT data-ready flag rearms that OUT endpoint
// - status stage gets NAK until acknowledge bit set, then ACK
// - acknowledge bit cleared by status ACK, setup, stall set, write 0
// - status-stall bit makes status stage answer STALL
// - setup token clears status-stall and both endpoint 0 halts
// - endpoint halt answers STALL regardless of other control bits, except the disable bit of endpoints 1 to 3
// - IN NAK sets that endpoint's refused-seen flag, sticky
// - disabled endpoints 1 to 3 ignore all traffic
// - endpoint 0 has no disable and always responds while controller is enabled
// - toggle-reset bit forces DATA0 then clears itself
// - bus reset clears the toggle-reset bits
// - endpoint 0 toggle handled internally
// - unused register bits read as zero
// - byte-count write arms IN endpoint to send data
`include "uesc_map.svh"
`default_nettype none
module uesc_top
  import uesc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // controller level
  input wire logic CTRL_EN,
  // indirect register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // byte-count write strobes: [0] ep0, [1] ep2, [2] ep3
  input wire logic [2:0] BC_WRITE,
  // serial engine
  input wire uesc_tok_s TOKEN,
  input wire uesc_ev_s EVENT,
  output uesc_resp_e RESP,
  output logic RESP_VALID,
  output logic [3:0] DATA_TOGGLE,
  // cpu interrupt
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction : reg_hit

  logic wr_en_reg;
  logic wr_flags;
  logic wr_stall;
  logic wr_nak;
  logic wr_dis;
  logic [5:0] irq_en_r;
  logic [5:0] flags_r;
  logic [5:0] flags_nxt;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [5:0] halt_r;
  logic [5:0] halt_nxt;
  logic ack_r;
  logic [2:0] nak_r;
  logic [2:0] nak_set;
  logic [2:0] off_r;
  logic [2:0] tgl_r;
  logic [2:0] armed_r;
  logic [7:0] rdata_r;
  uesc_resp_e resp_r;
  uesc_resp_e resp_nxt;
  logic resp_valid_r;

  assign wr_en_reg = REG_WR && CTRL_EN && reg_hit(REG_ADDR, `UESC_OFS_IRQ_EN);
  assign wr_flags = REG_WR && reg_hit(REG_ADDR, `UESC_OFS_IRQ_FLAGS);
  assign wr_stall = REG_WR && reg_hit(REG_ADDR, `UESC_OFS_STALL);
  assign wr_nak = REG_WR && reg_hit(REG_ADDR, `UESC_OFS_NAK);
  assign wr_dis = REG_WR && reg_hit(REG_ADDR, `UESC_OFS_DIS_TGL);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enables
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      irq_en_r <= `UESC_RST_IRQ_EN;
    else if (EVENT.bus_reset)
      irq_en_r <= `UESC_RST_IRQ_EN;
    else if (wr_en_reg)
      irq_en_r <= REG_WDATA[5:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event flags
  always_comb
  begin
    flag_set = '0;
    flag_set[`UESC_B_SETUP] = EVENT.setup_ok;
    flag_set[`UESC_B_EP3_TX] = EVENT.in_acked && EVENT.ep == 2'h3;
    flag_set[`UESC_B_EP2_TX] = EVENT.in_acked && EVENT.ep == 2'h2;
    flag_set[`UESC_B_EP0_TX] = EVENT.in_acked && EVENT.ep == 2'h0;
    flag_set[`UESC_B_EP1_RX] = EVENT.out_ok && EVENT.ep == 2'h1;
    flag_set[`UESC_B_EP0_RX] = EVENT.out_ok && EVENT.ep == 2'h0;
    flag_clr = wr_flags ? ~REG_WDATA[5:0] : 6'h00;
    flag_clr[`UESC_B_EP0_TX] = flag_clr[`UESC_B_EP0_TX] | BC_WRITE[0];
    flag_clr[`UESC_B_EP2_TX] = flag_clr[`UESC_B_EP2_TX] | BC_WRITE[1];
    flag_clr[`UESC_B_EP3_TX] = flag_clr[`UESC_B_EP3_TX] | BC_WRITE[2];
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      flags_r <= `UESC_RST_FLAGS;
    else
      flags_r <= flags_nxt;
  end

  assign IRQ = |(flags_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // stall and status-stage control
  always_comb
  begin
    halt_nxt = wr_stall ? REG_WDATA[5:0] : halt_r;
    if (EVENT.setup_token)
    begin
      halt_nxt[`UESC_B_STAT_STALL] = 1'b0;
      halt_nxt[`UESC_B_EP0_RX_HALT] = 1'b0;
      halt_nxt[`UESC_B_EP0_TX_HALT] = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      halt_r <= `UESC_RST_STALL;
    else
      halt_r <= halt_nxt;
  end

  // clears win over a same-cycle write of 1
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      ack_r <= 1'b0;
    else if (EVENT.status_acked || EVENT.setup_token || (wr_stall && |REG_WDATA[5:0]))
      ack_r <= 1'b0;
    else if (wr_stall)
      ack_r <= REG_WDATA[`UESC_B_ACK];
  end

  ////////////////////////////////////////////////////////////////////////////
  // refused-seen flags, disables, toggle resets, arming
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      nak_r <= 3'h0;
    else
      nak_r <= (nak_r & ~(wr_nak ? ~REG_WDATA[7:5] : 3'h0)) | nak_set;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      off_r <= 3'h0;
    else if (wr_dis)
      off_r <= REG_WDATA[7:5];
  end

  // toggle-reset bits live one cycle, so readback of 1 is only momentary
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      tgl_r <= 3'h0;
    else if (EVENT.bus_reset)
      tgl_r <= 3'h0;
    else if (wr_dis)
      tgl_r <= REG_WDATA[4:2];
    else
      tgl_r <= 3'h0;
  end

  // index 0 ep0, 1 ep2, 2 ep3; a new byte count wins over a same-cycle ack
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      armed_r <= 3'h0;
    else
      armed_r <= (armed_r & ~{EVENT.in_acked && EVENT.ep == 2'h3,
                              EVENT.in_acked && EVENT.ep == 2'h2,
                              EVENT.in_acked && EVENT.ep == 2'h0}) | BC_WRITE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake decision
  always_comb
  begin
    resp_nxt = RSP_NONE;
    nak_set = 3'h0;
    if (TOKEN.valid && CTRL_EN)
    begin
      unique case (TOKEN.ep)
        2'h0:
        begin
          if (TOKEN.is_in ? halt_r[`UESC_B_EP0_TX_HALT] : halt_r[`UESC_B_EP0_RX_HALT])
            resp_nxt = RSP_STALL;
          else if (TOKEN.status)
          begin
            if (halt_r[`UESC_B_STAT_STALL])
              resp_nxt = RSP_STALL;
            else if (ack_r)
              resp_nxt = RSP_ACK;
            else
              resp_nxt = RSP_NAK;
          end
          else if (TOKEN.is_in)
          begin
            resp_nxt = armed_r[0] ? RSP_DATA : RSP_NAK;
            nak_set[0] = !armed_r[0];
          end
          else
            resp_nxt = flags_r[`UESC_B_EP0_RX] ? RSP_NAK : RSP_ACK;
        end
        2'h1:
        begin
          if (off_r[0] || TOKEN.is_in)
            resp_nxt = RSP_NONE;
          else if (halt_r[`UESC_B_EP1_HALT])
            resp_nxt = RSP_STALL;
          else
            resp_nxt = flags_r[`UESC_B_EP1_RX] ? RSP_NAK : RSP_ACK;
        end
        2'h2:
        begin
          if (off_r[1] || !TOKEN.is_in)
            resp_nxt = RSP_NONE;
          else if (halt_r[`UESC_B_EP2_HALT])
            resp_nxt = RSP_STALL;
          else
          begin
            resp_nxt = armed_r[1] ? RSP_DATA : RSP_NAK;
            nak_set[1] = !armed_r[1];
          end
        end
        2'h3:
        begin
          if (off_r[2] || !TOKEN.is_in)
            resp_nxt = RSP_NONE;
          else if (halt_r[`UESC_B_EP3_HALT])
            resp_nxt = RSP_STALL;
          else
          begin
            resp_nxt = armed_r[2] ? RSP_DATA : RSP_NAK;
            nak_set[2] = !armed_r[2];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      resp_r <= RSP_NONE;
      resp_valid_r <= 1'b0;
    end
    else
    begin
      resp_r <= resp_nxt;
      resp_valid_r <= resp_nxt != RSP_NONE;
    end
  end

  assign RESP = resp_r;
  assign RESP_VALID = resp_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // data toggles, one per endpoint
  logic [3:0] tgl_clear;
  logic [3:0] tgl_adv;
  assign tgl_clear = {tgl_r, 1'b0} | {4{EVENT.bus_reset}};
  assign tgl_adv[0] = (EVENT.in_acked || EVENT.out_ok) && EVENT.ep == 2'h0;
  assign tgl_adv[1] = EVENT.out_ok && EVENT.ep == 2'h1;
  assign tgl_adv[2] = EVENT.in_acked && EVENT.ep == 2'h2;
  assign tgl_adv[3] = EVENT.in_acked && EVENT.ep == 2'h3;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_tgl
      uesc_toggle u_tgl (
        .clk(CLOCK),
        .rstn(RSTN),
        .clear(tgl_clear[i]),
        .force_one(i == 0 ? EVENT.setup_ok : 1'b0),
        .advance(tgl_adv[i]),
        .toggle_r(DATA_TOGGLE[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register readback, one cycle after the read strobe
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      rdata_r <= 8'h00;
    else if (REG_RD)
    begin
      if (reg_hit(REG_ADDR, `UESC_OFS_IRQ_EN))
        rdata_r <= CTRL_EN ? {2'h0, irq_en_r} : 8'h00;
      else if (reg_hit(REG_ADDR, `UESC_OFS_IRQ_FLAGS))
        rdata_r <= {2'h0, flags_r};
      else if (reg_hit(REG_ADDR, `UESC_OFS_STALL))
        rdata_r <= {1'b0, ack_r, halt_r};
      else if (reg_hit(REG_ADDR, `UESC_OFS_NAK))
        rdata_r <= {nak_r, 5'h00};
      else if (reg_hit(REG_ADDR, `UESC_OFS_DIS_TGL))
        rdata_r <= {off_r, tgl_r, 2'h0};
      else
        rdata_r <= 8'h00;
    end
  end

  assign REG_RDATA = rdata_r;

endmodule : uesc_top
`default_nettype wire
